// ### hw/sdtu_top.sv
// Operation
// - Class flag clear means system descriptor.
// - Types 1-7 decode as 16-bit forms.
// - Types 9,11,12,14,15 decode as 32-bit forms.
// - Types 0,8,10,13 are reserved.
// - Gates hold entry pointer or task selector.
// - Tables hold 8192 entries of 8 bytes.
// - Global table located only via held register.
// - Last valid byte is base plus limit.
// - Null global entry faults on memory use.
// - Local table register caches selector, base, limit.
// - Global/interrupt store writes 48-bit pseudo-descriptor.
// - Address mod four two: word then doubleword.
// - Class set: type top bit picks code.
module sdtu_top
(
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    input  wire logic                 ce,
    input  wire sdtu_pkg::sdtu_bus_t  bus,
    output logic [31:0]               bus_rdata,
    input  wire logic                 desc_valid,
    input  wire logic [31:0]          desc_hi,
    input  wire sdtu_pkg::sdtu_chk_t  chk,
    output logic                      chk_done,
    output logic                      gp_fault,
    output logic [31:0]               chk_addr,
    input  wire logic                 ldt_load,
    input  wire logic [15:0]          ldt_sel,
    input  wire logic [31:0]          ldt_base,
    input  wire logic [15:0]          ldt_limit,
    input  wire logic [7:0]           ldt_rights,
    input  wire logic                 store_req,
    input  wire logic [1:0]           store_sel,
    input  wire logic [31:0]          store_addr,
    output logic                      mem_we,
    output logic [31:0]               mem_addr,
    output logic [31:0]               mem_wdata,
    output logic [3:0]                mem_be,
    output logic                      store_busy,
    output logic                      irq
);
    import sdtu_pkg::*;

    // ****************************************************************
    // Table registers.
    // ****************************************************************
    logic [31:0] gbase_q, gbase_d;     // Global table base.
    logic [15:0] glim_q, glim_d;       // Global table limit.
    logic [31:0] ibase_q, ibase_d;     // Interrupt table base.
    logic [15:0] ilim_q, ilim_d;       // Interrupt table limit.
    logic [15:0] lsel_q, lsel_d;       // Local table selector.
    logic [31:0] lbase_q, lbase_d;     // Local table base.
    logic [15:0] llim_q, llim_d;       // Local table limit.
    logic [7:0]  lacc_q, lacc_d;       // Local table rights.
    logic [15:0] tsel_q, tsel_d;       // Task register selector.
    logic [EV_W-1:0] stat_q, stat_d;   // Sticky events.
    logic [EV_W-1:0] mask_q, mask_d;   // Interrupt mask.
    logic [31:0] rdata_q, rdata_d;     // Read data register.
    logic        irq_q, irq_d;         // Interrupt output register.
    sdtu_decode_t dec_q, dec_d;        // Last decoded descriptor.
    logic [EV_W-1:0] ev;               // Events this cycle.

    // ****************************************************************
    // Descriptor decode.
    // ****************************************************************
    // Pure decode of the high doubleword; result is latched on valid.
    always_comb
    begin
        logic [3:0] ty;
        ty = desc_hi[TYPE_LSB+3:TYPE_LSB];
        dec_d = dec_q;
        if (desc_valid)
        begin
            dec_d = '0;
            if (desc_hi[CLASS_BIT])
            begin
                // Top type bit selects code over data.
                dec_d.is_code = ty[3];
                dec_d.is_data = !ty[3];
            end
            else
            begin
                // Class clear: system encoding applies.
                unique case (ty)
                    SYS_TSS16_AV, SYS_LDT:
                        dec_d.is_sys_seg = 1'b1;
                    SYS_TSS16_BY:
                    begin
                        dec_d.is_sys_seg = 1'b1;
                        dec_d.is_busy    = 1'b1;
                    end
                    SYS_CALL16, SYS_INT16, SYS_TRAP16:
                    begin
                        dec_d.is_gate   = 1'b1;
                        dec_d.has_entry = 1'b1;
                    end
                    SYS_TASKGATE:
                    begin
                        dec_d.is_gate     = 1'b1;
                        dec_d.has_tss_sel = 1'b1;
                    end
                    SYS_TSS32_AV:
                    begin
                        dec_d.is_sys_seg = 1'b1;
                        dec_d.is_32bit   = 1'b1;
                    end
                    SYS_TSS32_BY:
                    begin
                        dec_d.is_sys_seg = 1'b1;
                        dec_d.is_32bit   = 1'b1;
                        dec_d.is_busy    = 1'b1;
                    end
                    SYS_CALL32, SYS_INT32, SYS_TRAP32:
                    begin
                        dec_d.is_gate   = 1'b1;
                        dec_d.is_32bit  = 1'b1;
                        dec_d.has_entry = 1'b1;
                    end
                    SYS_RSVD0, SYS_RSVD8, SYS_RSVD10, SYS_RSVD13:
                        dec_d.reserved = 1'b1;
                endcase
            end
        end
    end

    // ****************************************************************
    // Selector limit check.
    // ****************************************************************
    // The index is 13 bits, scaled by 8; the last byte of the entry
    // must not pass base plus limit, so offset plus seven is compared.
    logic [15:0] off;          // Byte offset of the entry.
    logic [16:0] last;         // Last byte of the entry, relative.
    logic [16:0] tlim;         // Limit of the chosen table.
    logic [31:0] tbase;        // Base of the chosen table.
    logic        chk_gp;       // Fault for this check.
    logic        chk_done_d, chk_done_q;
    logic        gp_d, gp_q;
    logic [31:0] caddr_d, caddr_q;

    always_comb
    begin
        off   = {chk.sel[15:3], 3'(0)};
        last  = {1'b0, off} + 17'(DESC_BYTES - 1);
        // Table bit chooses local; global uses only held values.
        tbase = chk.sel[2] ? lbase_q : gbase_q;
        tlim  = {1'b0, chk.sel[2] ? llim_q : glim_q};
        chk_gp = (last > tlim);
        // Null global entry loads fine but faults on memory use.
        if (!chk.sel[2] && chk.sel[15:3] == 13'h0000 && chk.mem_use)
            chk_gp = 1'b1;
        chk_done_d = chk.valid;
        gp_d       = chk.valid && chk_gp;
        caddr_d    = chk.valid ? tbase + {16'h0000, off} : caddr_q;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            chk_done_q <= 1'b0;
            gp_q       <= 1'b0;
            caddr_q    <= BASE_RST;
        end
        else if (ce)
        begin
            chk_done_q <= chk_done_d;
            gp_q       <= gp_d;
            caddr_q    <= caddr_d;
        end
    end

    // ****************************************************************
    // Pseudo-descriptor store sequencer.
    // ****************************************************************
    // The 48-bit image is limit low, base high; it goes out as a word
    // then a doubleword, both aligned when the address is 2 mod 4.
    sdtu_st_t    st_q, st_d;
    logic [47:0] img_q, img_d;       // Image being stored.
    logic [31:0] sa_q, sa_d;         // Current store address.
    logic        we_q, we_d, busy_q, busy_d;
    logic [31:0] ma_q, ma_d;
    logic [31:0] wd_q, wd_d;
    logic [3:0]  be_q, be_d;
    logic        st_fin;             // Store finished this cycle.

    always_comb
    begin
        st_d  = st_q;
        img_d = img_q;
        sa_d  = sa_q;
        we_d  = 1'b0;
        ma_d  = ma_q;
        wd_d  = wd_q;
        be_d  = be_q;
        st_fin = 1'b0;
        unique case (st_q)
            ST_IDLE:
                if (store_req)
                begin
                    sa_d = store_addr;
                    unique case (store_sel)
                        STORE_GLOBAL: img_d = {gbase_q, glim_q};
                        STORE_INTR:   img_d = {ibase_q, ilim_q};
                        STORE_LOCAL:  img_d = {32'h0, lsel_q};
                        STORE_TASK:   img_d = {32'h0, tsel_q};
                    endcase
                    st_d = ST_WORD;
                end
            ST_WORD:
            begin
                // Aligned word: lanes follow address bit 1.
                we_d = 1'b1;
                ma_d = {sa_q[31:2], 2'h0};
                wd_d = sa_q[1] ? {img_q[15:0], 16'h0000}
                               : {16'h0000, img_q[15:0]};
                be_d = sa_q[1] ? 4'hc : 4'h3;
                // Selector stores end after the word.
                st_d = (store_sel[1]) ? ST_DONE : ST_DWORD;
                sa_d = sa_q + 32'h0000_0002;
            end
            ST_DWORD:
            begin
                we_d = 1'b1;
                ma_d = sa_q;
                wd_d = img_q[47:16];
                be_d = 4'hf;
                st_d = ST_DONE;
            end
            ST_DONE:
            begin
                st_fin = 1'b1;
                st_d   = ST_IDLE;
            end
        endcase
        busy_d = (st_d != ST_IDLE);
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            st_q  <= ST_IDLE;
            img_q <= 48'h0;
            sa_q  <= BASE_RST;
            we_q  <= 1'b0;
            ma_q  <= BASE_RST;
            wd_q  <= 32'h0;
            be_q  <= 4'h0;
            busy_q <= 1'b0;
        end
        else if (ce)
        begin
            st_q  <= st_d;
            img_q <= img_d;
            sa_q  <= sa_d;
            we_q  <= we_d;
            ma_q  <= ma_d;
            wd_q  <= wd_d;
            be_q  <= be_d;
            busy_q <= busy_d;
        end
    end

    // ****************************************************************
    // Registers, events and interrupt.
    // ****************************************************************
    // Bus writes and local-table loads; set of a flag beats its clear.
    always_comb
    begin
        gbase_d = gbase_q;
        glim_d  = glim_q;
        ibase_d = ibase_q;
        ilim_d  = ilim_q;
        lsel_d  = lsel_q;
        lbase_d = lbase_q;
        llim_d  = llim_q;
        lacc_d  = lacc_q;
        tsel_d  = tsel_q;
        mask_d  = mask_q;
        ev = '0;
        ev[EV_GP]     = gp_d;
        ev[EV_RSVD]   = desc_valid && dec_d.reserved;
        ev[EV_STORED] = st_fin;
        stat_d = stat_q;
        if (bus.wr)
        begin
            unique case (bus.addr)
                REG_GBASE: gbase_d = bus.wdata;
                REG_GLIM:  glim_d  = bus.wdata[15:0];
                REG_IBASE: ibase_d = bus.wdata;
                REG_ILIM:  ilim_d  = bus.wdata[15:0];
                REG_MASK:  mask_d  = bus.wdata[EV_W-1:0];
                REG_STATUS: stat_d = stat_q & ~bus.wdata[EV_W-1:0];
                default: tsel_d = tsel_q;
            endcase
        end
        if (ldt_load)
        begin
            lsel_d  = ldt_sel;
            lbase_d = ldt_base;
            llim_d  = ldt_limit;
            lacc_d  = ldt_rights;
        end
        stat_d = stat_d | ev;
        irq_d  = |(stat_d & mask_d);
        unique case (bus.addr)
            REG_STATUS: rdata_d = {29'h0, stat_q};
            REG_MASK:   rdata_d = {29'h0, mask_q};
            REG_GBASE:  rdata_d = gbase_q;
            REG_GLIM:   rdata_d = {16'h0, glim_q};
            REG_LSEL:   rdata_d = {16'h0, lsel_q};
            REG_LBASE:  rdata_d = lbase_q;
            REG_LLIM:   rdata_d = {16'h0, llim_q};
            REG_LACC:   rdata_d = {24'h0, lacc_q};
            REG_IBASE:  rdata_d = ibase_q;
            REG_ILIM:   rdata_d = {16'h0, ilim_q};
            REG_DECODE: rdata_d = {23'h0, dec_q};
            default:    rdata_d = 32'h0;
        endcase
        if (!bus.rd)
            rdata_d = 32'h0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            gbase_q <= BASE_RST;
            glim_q  <= LIMIT_RST;
            ibase_q <= BASE_RST;
            ilim_q  <= LIMIT_RST;
            lsel_q  <= 16'h0;
            lbase_q <= BASE_RST;
            llim_q  <= LIMIT_RST;
            lacc_q  <= 8'h0;
            tsel_q  <= 16'h0;
            stat_q  <= '0;
            mask_q  <= '0;
            rdata_q <= 32'h0;
            irq_q   <= 1'b0;
            dec_q   <= '0;
        end
        else if (ce)
        begin
            gbase_q <= gbase_d;
            glim_q  <= glim_d;
            ibase_q <= ibase_d;
            ilim_q  <= ilim_d;
            lsel_q  <= lsel_d;
            lbase_q <= lbase_d;
            llim_q  <= llim_d;
            lacc_q  <= lacc_d;
            tsel_q  <= tsel_d;
            stat_q  <= stat_d;
            mask_q  <= mask_d;
            rdata_q <= rdata_d;
            irq_q   <= irq_d;
            dec_q   <= dec_d;
        end
    end

    // Outputs straight from flip-flops.
    assign bus_rdata  = rdata_q;
    assign chk_done   = chk_done_q;
    assign gp_fault   = gp_q;
    assign chk_addr   = caddr_q;
    assign mem_we     = we_q;
    assign mem_addr   = ma_q;
    assign mem_wdata  = wd_q;
    assign mem_be     = be_q;
    assign store_busy = busy_q;
    assign irq        = irq_q;

endmodule

// ### shared/sdtu_pkg.sv
package sdtu_pkg;

    // ****************************************************************
    // Descriptor layout and sizes.
    // ****************************************************************
    localparam int DESC_BYTES     = 8;         // Bytes per descriptor.
    localparam int TYPE_LSB       = 8;         // Type field, high word.
    localparam int CLASS_BIT      = 12;        // Descriptor-class flag.
    localparam logic [31:0] BASE_RST  = 32'h0000_0000; // Base after reset.
    localparam logic [15:0] LIMIT_RST = 16'h0000;      // Limit after reset.

    // ****************************************************************
    // Register offsets and interrupt bits.
    // ****************************************************************
    localparam logic [3:0] REG_STATUS = 4'h0;  // Sticky event flags.
    localparam logic [3:0] REG_MASK   = 4'h1;  // Interrupt mask.
    localparam logic [3:0] REG_GBASE  = 4'h2;  // Global table base.
    localparam logic [3:0] REG_GLIM   = 4'h3;  // Global table limit.
    localparam logic [3:0] REG_LSEL   = 4'h4;  // Local table selector.
    localparam logic [3:0] REG_LBASE  = 4'h5;  // Local table base.
    localparam logic [3:0] REG_LLIM   = 4'h6;  // Local table limit.
    localparam logic [3:0] REG_LACC   = 4'h7;  // Local table rights.
    localparam logic [3:0] REG_IBASE  = 4'h8;  // Interrupt table base.
    localparam logic [3:0] REG_ILIM   = 4'h9;  // Interrupt table limit.
    localparam logic [3:0] REG_DECODE = 4'ha;  // Last decode result.
    localparam int EV_GP      = 0;             // Protection fault event.
    localparam int EV_RSVD    = 1;             // Reserved type event.
    localparam int EV_STORED  = 2;             // Store finished event.
    localparam int EV_W       = 3;

    // ****************************************************************
    // System type encodings.
    // ****************************************************************
    typedef enum logic [3:0] {
        SYS_RSVD0   = 4'h0, SYS_TSS16_AV = 4'h1, SYS_LDT     = 4'h2,
        SYS_TSS16_BY = 4'h3, SYS_CALL16  = 4'h4, SYS_TASKGATE = 4'h5,
        SYS_INT16   = 4'h6, SYS_TRAP16   = 4'h7, SYS_RSVD8   = 4'h8,
        SYS_TSS32_AV = 4'h9, SYS_RSVD10  = 4'ha, SYS_TSS32_BY = 4'hb,
        SYS_CALL32  = 4'hc, SYS_RSVD13   = 4'hd, SYS_INT32   = 4'he,
        SYS_TRAP32  = 4'hf
    } sdtu_sys_type_t;

    // Decoded class of a descriptor.
    typedef struct packed {
        logic       is_data;      // Code/data class, data kind.
        logic       is_code;      // Code/data class, code kind.
        logic       is_sys_seg;   // Task-state or local-table segment.
        logic       is_gate;      // Call, interrupt, trap or task gate.
        logic       has_entry;    // Gate holds a code entry point.
        logic       has_tss_sel;  // Gate holds a task-state selector.
        logic       is_32bit;     // 32-bit form.
        logic       is_busy;      // Busy task-state segment.
        logic       reserved;     // Reserved system encoding.
    } sdtu_decode_t;

    // Register bus request.
    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } sdtu_bus_t;

    // Selector check request from execution.
    typedef struct packed {
        logic        valid;
        logic [15:0] sel;        // Index, table bit, requested level.
        logic        mem_use;    // Memory access through this selector.
    } sdtu_chk_t;

    // Store state machine.
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_WORD  = 4'b0010,
        ST_DWORD = 4'b0100,
        ST_DONE  = 4'b1000
    } sdtu_st_t;

    // Store selections.
    localparam logic [1:0] STORE_GLOBAL = 2'h0;
    localparam logic [1:0] STORE_INTR   = 2'h1;
    localparam logic [1:0] STORE_LOCAL  = 2'h2;
    localparam logic [1:0] STORE_TASK   = 2'h3;

endpackage

// ### sim/sdtu_asserts.sv
// ****************************************************************
// Checker for the descriptor table unit, seen from its ports only.
// ****************************************************************
module sdtu_asserts
    import sdtu_pkg::*;
(
    input wire logic                clk_sys,
    input wire logic                rst,
    input wire logic                ce,
    input wire sdtu_pkg::sdtu_chk_t chk,
    input wire logic                chk_done,
    input wire logic                gp_fault,
    input wire logic [31:0]         chk_addr,
    input wire logic                ldt_load,
    input wire logic [31:0]         ldt_base,
    input wire logic [15:0]         ldt_limit,
    input wire logic                store_req,
    input wire logic [1:0]          store_sel,
    input wire logic                mem_we,
    input wire logic [31:0]         mem_addr,
    input wire logic [3:0]          mem_be,
    input wire logic                store_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    logic [31:0] lbase_q, lbase_d; // Shadow of the local table base.
    logic [15:0] llim_q, llim_d;   // Shadow of the local table limit.
    logic        gp_loc;           // Expected fault of a local check.
    logic [31:0] la_loc;           // Expected address of a local check.

    // Shadow the local table register so checks need no design state.
    always_comb
    begin
        lbase_d = lbase_q;
        llim_d  = llim_q;
        if (ce && ldt_load)
        begin
            lbase_d = ldt_base;
            llim_d  = ldt_limit;
        end
    end

    // Register the shadow.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            lbase_q <= BASE_RST;
            llim_q  <= LIMIT_RST;
        end
        else
        begin
            lbase_q <= lbase_d;
            llim_q  <= llim_d;
        end
    end

    assign gp_loc = {chk.sel[15:3], 3'h7} > llim_q;
    assign la_loc = lbase_q + {16'h0, chk.sel[15:3], 3'h0};

    a_chk_answer: assert property (ce && chk.valid |=> chk_done)
        else $error("check not answered in one cycle");
    a_gp_with_done: assert property (gp_fault |-> chk_done)
        else $error("fault without a check answer");
    a_null_fault: assert property (ce && chk.valid &&
        chk.sel[15:2] == 14'h0 && chk.mem_use |=> gp_fault)
        else $error("null entry use did not fault");
    a_local_limit: assert property (ce && chk.valid && chk.sel[2]
        |=> gp_fault == $past(gp_loc))
        else $error("local limit fault wrong");
    a_local_addr: assert property (ce && chk.valid && chk.sel[2]
        |=> chk_addr == $past(la_loc))
        else $error("local entry address wrong");
    a_store_word: assert property (ce && store_req && !store_busy
        |=> store_busy ##1 (mem_we && mem_addr[1:0] == 2'h0))
        else $error("store did not start with aligned word");
    a_pseudo_dword: assert property ($rose(store_busy) &&
        !store_sel[1] |-> ##2 (mem_we && mem_be == 4'hf))
        else $error("pseudo-descriptor dword missing");
    a_short_store: assert property ($rose(store_busy) &&
        store_sel[1] |-> ##2 !mem_we)
        else $error("selector store wrote a second unit");
    a_word_lanes: assert property (mem_we && !$past(mem_we)
        |-> (mem_be == 4'h3 || mem_be == 4'hc))
        else $error("word store lanes wrong");
endmodule

bind sdtu_top sdtu_asserts u_asserts (.*);

// ### sim/sdtu_mem_model.sv
// ****************************************************************
// System memory holding the tables; takes byte-lane writes at once.
// ****************************************************************
module sdtu_mem_model
(
    input wire logic        clk_sys,
    input wire logic        mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic [3:0]  mem_be
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] words [16]; // Small window; upper address bits ignored.

    // Fill with a pattern so lanes left unwritten never look right.
    initial words = '{default: 32'ha5a5_a5a5};

    // Only enabled lanes change, so a wrong lane shows as stale data.
    always @(posedge clk_sys)
        if (mem_we)
            for (int b = 0; b < 4; b++)
                if (mem_be[b])
                    words[mem_addr[5:2]][8*b +: 8] <= mem_wdata[8*b +: 8];
endmodule

// ### sim/tb.sv
module tb;
    import sdtu_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rst = 1, ce = 1, desc_valid = 0, ldt_load = 0;
    logic chk_done, gp_fault, store_req = 0, mem_we, store_busy, irq;
    sdtu_bus_t   bus = '0;
    sdtu_chk_t   chk = '0;
    logic [31:0] bus_rdata, desc_hi = 0, chk_addr, ldt_base = 0, d, h;
    logic [31:0] store_addr = 0, mem_addr, mem_wdata, gb, ib;
    logic [15:0] ldt_sel = 0, ldt_limit = 0, gl, il;
    logic [7:0]  ldt_rights = 0;
    logic [1:0]  store_sel = 0;
    logic [3:0]  mem_be;
    logic [31:0] seed = 32'd61996; // Fixed seed keeps runs repeatable.
    int          bad_count = 0, checks_done = 0;

    sdtu_top i_dut (.*);
    sdtu_mem_model u_mem (.*);

    // ****************************************************************
    // Helpers: random source, expectations, bus cycles.
    // ****************************************************************
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected decode word, bits 8 to 0 as in the struct.
    function logic [31:0] dexp(logic [31:0] v);
        logic [3:0] t;
        t = v[11:8];
        if (v[12])
            return {23'h0, ~t[3], t[3], 7'h0};
        return {23'h0, 2'b00, t inside {1, 2, 3, 9, 11},
            t inside {[4:7], 12, 14, 15}, t inside {4, 6, 7, 12, 14, 15},
            t == 4'h5, t[3] && !(t inside {8, 10, 13}),
            t == 4'h3 || t == 4'hb, t inside {0, 8, 10, 13}};
    endfunction

    task cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        bus.addr <= a;
        bus.wdata <= v;
        bus.wr <= 1'b1;
        @(posedge clk_sys);
        bus.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task rd(input logic [3:0] a);
        @(posedge clk_sys);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        #1 d = bus_rdata;
    endtask

    // One selector check against a known table base and limit.
    task ck(input logic [15:0] s, input logic m, input logic [31:0] b,
            input logic [15:0] l);
        logic [31:0] off;
        off = {16'h0, s[15:3], 3'h0};
        @(posedge clk_sys);
        chk <= '{valid: 1'b1, sel: s, mem_use: m};
        @(posedge clk_sys);
        chk.valid <= 1'b0;
        #1 cmp(chk_addr, b + off);
        cmp({30'h0, chk_done, gp_fault}, {30'h0, 1'b1,
            (off + 32'h7 > {16'h0, l}) || (s[15:2] == 14'h0 && m)});
    endtask

    // Store request, then a bounded wait for the machine to go idle.
    task st(input logic [1:0] s, input logic [31:0] a);
        @(posedge clk_sys);
        store_sel <= s;
        store_addr <= a;
        store_req <= 1'b1;
        @(posedge clk_sys);
        store_req <= 1'b0;
        tick(4);
        #1 cmp({31'h0, store_busy}, 32'h0);
    endtask

    task close_out;
        $display("comparisons %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ****************************************************************
    // Clock, watchdog and main sequence.
    // ****************************************************************
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // About 280 cycles run; some 140 times that is allowed.
    initial
    begin
        #1000000;
        bad_count++;
        close_out;
    end

    initial
    begin
        tick(5);
        rst <= 1'b0;
        rd(REG_GBASE); cmp(d, BASE_RST);
        rd(REG_GLIM); cmp(d, {16'h0, LIMIT_RST});
        rd(4'hf); cmp(d, 32'h0);
        // Every system type, then code and data classes at random.
        for (int t = 0; t < 24; t++)
        begin
            h = rnd();
            h[12] = t > 15;
            if (t < 16)
                h[11:8] = t[3:0];
            @(posedge clk_sys);
            desc_hi <= h;
            desc_valid <= 1'b1;
            @(posedge clk_sys);
            desc_valid <= 1'b0;
            rd(REG_DECODE); cmp(d, dexp(h));
        end
        rd(REG_STATUS); cmp({31'h0, d[EV_RSVD]}, 32'h1);
        wr(REG_STATUS, 32'h7);
        rd(REG_STATUS); cmp(d, 32'h0);
        // Global table with an aligned base and an 8N-1 limit.
        gb = rnd() & 32'hffff_fff8;
        d = rnd();
        gl = {5'h0, d[7:0], 3'h7};
        wr(REG_GBASE, gb);
        wr(REG_GLIM, {16'h0, gl});
        ck(16'h0000, 1'b0, gb, gl);
        ck(16'h0003, 1'b1, gb, gl);
        ck({gl[15:3], 3'h0}, 1'b1, gb, gl);
        ck({gl[15:3] + 13'h1, 3'h0}, 1'b0, gb, gl);
        for (int i = 0; i < 30; i++)
        begin
            d = rnd();
            ck({d[15:3], 1'b0, d[1:0]}, d[16], gb, gl);
        end
        // Local table register is cached from one load.
        d = rnd();
        @(posedge clk_sys);
        ldt_sel <= d[15:0];
        ldt_base <= rnd();
        ldt_limit <= {4'h0, d[27:16]};
        ldt_rights <= d[23:16];
        ldt_load <= 1'b1;
        @(posedge clk_sys);
        ldt_load <= 1'b0;
        rd(REG_LSEL); cmp(d, {16'h0, ldt_sel});
        rd(REG_LBASE); cmp(d, ldt_base);
        rd(REG_LLIM); cmp(d, {16'h0, ldt_limit});
        rd(REG_LACC); cmp(d, {24'h0, ldt_rights});
        for (int i = 0; i < 20; i++)
        begin
            d = rnd();
            ck({d[15:3], 1'b1, d[1:0]}, d[16], ldt_base, ldt_limit);
        end
        // Stores land in memory; events stay masked meanwhile.
        ib = rnd();
        il = ib[15:0];
        wr(REG_MASK, 32'h0);
        wr(REG_STATUS, 32'h7);
        wr(REG_IBASE, ib);
        wr(REG_ILIM, {16'h0, il});
        st(STORE_GLOBAL, 32'h12);
        cmp({16'h0, u_mem.words[4][31:16]}, {16'h0, gl});
        cmp(u_mem.words[5], gb);
        st(STORE_INTR, 32'h22);
        cmp({16'h0, u_mem.words[8][31:16]}, {16'h0, il});
        cmp(u_mem.words[9], ib);
        st(STORE_LOCAL, 32'h30);
        cmp({16'h0, u_mem.words[12][15:0]}, {16'h0, ldt_sel});
        st(STORE_TASK, 32'h34);
        #1 cmp({31'h0, irq}, 32'h0);
        wr(REG_MASK, 32'h7);
        tick(2);
        #1 cmp({31'h0, irq}, 32'h1);
        wr(REG_STATUS, 32'h7);
        tick(2);
        #1 cmp({31'h0, irq}, 32'h0);
        rd(REG_STATUS); cmp(d, 32'h0);
        close_out;
    end
endmodule
